// File: generic_serial_host_mode_host_pkg.sv
package generic_serial_host_mode_host_pkg;

   // System clock and serial clock limits
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned SCLK_MAX_MHZ  = 50;
   // Least half period in system cycles, rounded up so the link never beats the limit
   localparam int unsigned SCLK_HALF_MIN = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);

   // Transfer size limits
   localparam int unsigned FRAME_MAX_BYTES = 2048;
   localparam int unsigned LEN_W           = 10;
   localparam int unsigned BIT_W           = 5;
   localparam logic [LEN_W-1:0] WORDS_MAX  = LEN_W'(FRAME_MAX_BYTES / 4);

   // Register offsets of the host's own APB map
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMD     = 8'h04;
   localparam logic [7:0] OFS_LEN     = 8'h08;
   localparam logic [7:0] OFS_TXDATA  = 8'h0c;
   localparam logic [7:0] OFS_RXDATA  = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_DEVSTAT = 8'h18;

   // Control register fields
   localparam int unsigned CTRL_START   = 0;
   localparam int unsigned CTRL_MODE    = 1;
   localparam int unsigned CTRL_WORD32  = 3;
   localparam int unsigned CTRL_BIG     = 4;
   localparam int unsigned CTRL_STAT_EN = 5;
   localparam int unsigned CTRL_IRQ_POL = 6;
   localparam int unsigned CTRL_WAKE    = 7;

   // Status register fields
   localparam int unsigned STS_BUSY     = 0;
   localparam int unsigned STS_TX_FULL  = 1;
   localparam int unsigned STS_RX_FULL  = 2;
   localparam int unsigned STS_DONE     = 3;
   localparam int unsigned STS_REFUSED  = 4;
   localparam int unsigned STS_IRQ      = 5;
   localparam int unsigned STS_DEV_ERR  = 6;
   localparam int unsigned STS_PREP     = 7;
   localparam int unsigned STS_PKT_IRQ  = 8;
   localparam int unsigned STS_PKT_AVL  = 9;

   // Values after reset
   localparam logic RST_WORD32  = 1'b0;
   localparam logic RST_BIG     = 1'b0;
   localparam logic RST_STAT_EN = 1'b1;
   localparam logic RST_IRQ_POL = 1'b1;

   // Device status word fields
   localparam int unsigned DST_NOT_AVAIL = 0;
   localparam int unsigned DST_UNDERFLOW = 1;
   localparam int unsigned DST_OVERFLOW  = 2;
   localparam int unsigned DST_PKT_IRQ   = 3;
   localparam int unsigned DST_RX_READY  = 5;
   localparam int unsigned DST_PKT_AVAIL = 8;
   localparam int unsigned DST_LEN_LO    = 9;
   localparam int unsigned DST_LEN_HI    = 19;

   // Device configuration function: wake-up bit in the register at address 0
   localparam logic [31:0] CFG_WAKE_ADDR = 32'h0000_0000;
   localparam logic [31:0] WAKE_WORD     = 32'h0000_0080;

   typedef enum logic [1:0] {MODE_WRITE, MODE_WRRD, MODE_CMD, MODE_RDDATA} mode_t;

   // Byte order on the wire; applying it twice gives back the word
   function automatic logic [31:0] order_word(input logic [31:0] w, input logic word32, input logic big);
      logic [31:0] o;
      if (big) begin
         o = {w[7:0], w[15:8], w[23:16], w[31:24]};
      end else if (word32) begin
         o = w;
      end else begin
         o = {w[15:0], w[31:16]};
      end
      return o;
   endfunction : order_word

endpackage : generic_serial_host_mode_host_pkg

// File: sclk_link_if.sv
`timescale 1ns/10ps
interface sclk_link_if;
   logic run;
   logic rise;
   logic fall;
   logic sclk;
   modport gen (input run, output rise, output fall, output sclk);
   modport eng (output run, input rise, input fall, input sclk);
endinterface : sclk_link_if

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  logic         clk_i,
   input  logic         arst_n_i,
   input  logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_t;

   sync_t r, next_r;

   if (W < 1) begin : g_bad_w
      $error("pin_sync needs at least one bit");
   end

   // Two stages; the first is read by the second only
   always_comb begin
      next_r      = r;
      next_r.meta = d_i;
      next_r.sync = r.meta;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.sync;
endmodule : pin_sync

// File: sclk_gen.sv
`timescale 1ns/10ps
module sclk_gen
   import generic_serial_host_mode_host_pkg::*;
#(
   parameter int unsigned HALF = SCLK_HALF_MIN
) (
   input  logic      clk_i,
   input  logic      arst_n_i,
   sclk_link_if.gen  lk
);
   localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          sclk;
   } gen_t;

   gen_t r, next_r;
   logic tick;

   // Anything shorter would run the link above its limit
   if (HALF < SCLK_HALF_MIN) begin : g_bad_half // RL5
      $error("sclk_gen half period below the serial clock limit");
   end

   // Toggle pulses, one system cycle each
   assign tick    = lk.run && (r.cnt == CW'(HALF - 1));
   assign lk.rise = tick && !r.sclk;
   assign lk.fall = tick && r.sclk;
   assign lk.sclk = r.sclk;

   // Divider; stopping the clock parks it low
   always_comb begin
      next_r = r;
      if (!lk.run) begin
         next_r.cnt  = '0;
         next_r.sclk = 1'b0;
      end else if (tick) begin
         next_r.cnt  = '0;
         next_r.sclk = !r.sclk;
      end else begin
         next_r.cnt = r.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : sclk_gen

// File: generic_serial_host_mode_host.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Contract
// RL1 - Device reuses card pins: data out, interrupt, chip select, data in.
// RL2 - Words are 16 or 32 bits; shifting aligns to the chosen word size. The host always shifts 32-bit words; word32 only sets the byte order.
// RL3 - Byte order little or big endian in both word sizes.
// RL4 - Each transaction opens with a 32-bit command word on data in.
// RL5 - Host never runs the serial clock above 50 MHz.
// RL6 - One transfer carries at most 2 KB of frame data.
// RL7 - Device returns data a fixed delay after the command.
// RL8 - Device shift edge is configurable.
// RL9 - Host shows first bit half a period early, later bits on falling edges.
// RL10 - Device captures command and write data on the active edge.
// RL11 - In write/read the first read bit is valid before the first rising edge.
// RL12 - A plain read is always preceded by a separate preparing write.
// RL13 - Plain read raises chip select between command and data phases.
// RL14 - Device may return a status word after each read or write.
// RL15 - A configuration bit disables status without changing phase timing.
// RL16 - Status bits 0 to 2: data not available, underflow, overflow.
// RL17 - Status bit 3 packet channel interrupt, bit 5 receive FIFO ready.
// RL18 - Status bit 8 packet waiting, bits 9 to 19 its length.
// RL19 - Host writes 1 to the wake-up bit to start the device.
// RL20 - Host uses the same wake-up procedure to leave sleep.
// RL21 - Device raises its interrupt line when it has news.
// RL22 - On interrupt the host reads interrupt or status to find the cause.
// RL23 - Wake-up is bit 7 of configuration register 0x00.
// RL24 - Configuration bit 4 picks rising-only or rising/falling edge use.
// RL25 - Configuration bit 5 sets interrupt polarity, high by default.
// RL26 - Configuration 0x0002 bit 0 enables status, default on.
// RL27 - Chip select low frames one transaction; partial words dropped at its rise.
// RL28 - Device drives zeros while the host sends command and write data; the device model sends its reply words during write data.
module generic_serial_host_mode_host
   import generic_serial_host_mode_host_pkg::*;
#(
   parameter int unsigned SCLK_HALF = SCLK_HALF_MIN
) (
   input  logic        clk_i,
   input  logic        arst_n_i,
   input  logic        psel_i,
   input  logic        penable_i,
   input  logic        pwrite_i,
   input  logic [7:0]  paddr_i,
   input  logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic        pready_o,
   output logic        pslverr_o,
   output logic        sclk_o,
   output logic        cs_n_o,
   output logic        serial_data_in_o,
   input  logic        serial_data_out_i,
   input  logic        dev_irq_i
);
   typedef enum logic [1:0] {E_IDLE, E_SHIFT, E_WAIT, E_END} eng_t;
   typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_STAT} phase_t;

   typedef struct packed {
      eng_t             st;
      phase_t           ph;
      mode_t            mode;
      logic             word32;
      logic             big;
      logic             stat_en;
      logic             irq_pol;
      logic             wake;
      logic [31:0]      cmd;
      logic [LEN_W-1:0] len;
      logic [31:0]      txdata;
      logic             tx_full;
      logic [31:0]      rxdata;
      logic             rx_full;
      logic             done;
      logic             refused;
      logic             prep;
      logic [31:0]      devstat;
      logic [LEN_W-1:0] left;
      logic [31:0]      tx_sh;
      logic [31:0]      rx_sh;
      logic [BIT_W-1:0] cnt;
      logic             word_done;
      logic             cs_n;
      logic             mosi;
      logic             run;
      logic [31:0]      prdata;
   } state_t;

   state_t      r, next_r;
   logic [1:0]  sync_q;
   logic        dout_s;
   logic        irq_s;
   logic        irq_act;
   logic        setup;
   logic        access;
   logic        wr;
   logic        rx_store;
   logic        refuse_rd;

   sclk_link_if lk ();

   function automatic logic is_mapped(input logic [7:0] a);
      return a inside {OFS_CTRL, OFS_CMD, OFS_LEN, OFS_TXDATA, OFS_RXDATA, OFS_STATUS, OFS_DEVSTAT};
   endfunction : is_mapped

   // Device data out and interrupt come from outside the clock domain
   pin_sync #(
      .W        (2)
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({dev_irq_i, serial_data_out_i}), // RL1
      .q_o      (sync_q)
   );

   // Serial clock made here by division, so it is no second domain
   sclk_gen #(
      .HALF     (SCLK_HALF)
   ) u_gen (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .lk       (lk.gen)
   );

   // Pin and bus handshake
   assign dout_s    = sync_q[0];
   assign irq_s     = sync_q[1];
   assign irq_act   = (irq_s == r.irq_pol); // RL25 RL21
   assign lk.run    = r.run;
   assign setup     = psel_i && !penable_i;
   assign access    = psel_i && penable_i;
   assign wr        = access && pwrite_i;
   assign pready_o  = 1'b1;                  // Zero wait states
   assign pslverr_o = access && !is_mapped(paddr_i);

   // Register writes first, engine next, so a hardware set beats a software clear
   always_comb begin
      logic             wk;
      logic             fin;
      mode_t            md;
      logic [LEN_W-1:0] ln;
      logic [31:0]      rd;
      wk        = 1'b0;
      fin       = 1'b0;
      md        = MODE_WRITE;
      ln        = '0;
      rd        = '0;
      next_r    = r;
      rx_store  = 1'b0;
      refuse_rd = 1'b0;

      if (wr && paddr_i == OFS_CTRL) begin
         // Configuration only moves between transactions
         if (r.st == E_IDLE) begin
            next_r.mode    = mode_t'(pwdata_i[CTRL_MODE +: 2]);
            next_r.word32  = pwdata_i[CTRL_WORD32];
            next_r.big     = pwdata_i[CTRL_BIG];
            next_r.stat_en = pwdata_i[CTRL_STAT_EN];
            next_r.irq_pol = pwdata_i[CTRL_IRQ_POL];
         end
         if (pwdata_i[CTRL_START]) begin
            wk = pwdata_i[CTRL_WAKE];
            md = wk ? MODE_WRITE : mode_t'(pwdata_i[CTRL_MODE +: 2]);       // RL19 RL20
            ln = wk ? LEN_W'(1) : r.len;
            refuse_rd = (md == MODE_RDDATA) && !r.prep;                     // RL12
            if (r.st != E_IDLE || ln == '0 || ln > WORDS_MAX || refuse_rd) begin // RL6
               next_r.refused = 1'b1;
            end else begin
               next_r.mode      = md;
               next_r.wake      = wk;
               next_r.left      = ln;
               next_r.cs_n      = 1'b0;                                     // RL27
               next_r.cnt       = '0;
               next_r.word_done = 1'b0;
               if (md == MODE_RDDATA) begin
                  // Data half of a split read opens without a command
                  next_r.ph   = PH_DATA;
                  next_r.st   = E_WAIT;
                  next_r.prep = 1'b0;
               end else begin
                  next_r.ph    = PH_CMD;
                  next_r.st    = E_SHIFT;
                  next_r.run   = 1'b1;
                  next_r.tx_sh = order_word(r.cmd, next_r.word32, next_r.big); // RL4 RL3
                  next_r.mosi  = next_r.tx_sh[31];                          // RL9
               end
            end
         end
      end
      if (wr && paddr_i == OFS_CMD) begin
         next_r.cmd = pwdata_i;
      end
      if (wr && paddr_i == OFS_LEN) begin
         next_r.len = pwdata_i[LEN_W-1:0];
      end
      if (wr && paddr_i == OFS_STATUS) begin
         if (pwdata_i[STS_DONE]) begin
            next_r.done = 1'b0;
         end
         if (pwdata_i[STS_REFUSED]) begin
            next_r.refused = 1'b0;
         end
      end
      if (access && !pwrite_i && paddr_i == OFS_RXDATA) begin
         next_r.rx_full = 1'b0;
      end

      // Transaction engine
      unique case (r.st)
         E_IDLE: begin
            // Keep the select that an accepted start has just lowered
            next_r.cs_n = (next_r.st == E_IDLE);
         end
         E_SHIFT: begin
            if (lk.rise) begin
               // Host samples on the rising edge only
               next_r.rx_sh     = {r.rx_sh[30:0], dout_s};                  // RL11 RL24 RL7
               next_r.cnt       = r.cnt + BIT_W'(1);
               next_r.word_done = (r.cnt == '1);                            // RL2
            end
            if (lk.fall && !r.word_done) begin
               next_r.tx_sh = {r.tx_sh[30:0], 1'b0};
               next_r.mosi  = r.tx_sh[30];                                  // RL9
            end else if (lk.fall) begin
               next_r.word_done = 1'b0;
               unique case (r.ph)
                  PH_CMD: begin
                     if (r.mode == MODE_CMD) begin
                        fin = 1'b1;                                         // RL13
                     end else begin
                        next_r.ph  = PH_DATA;
                        next_r.run = 1'b0;
                        next_r.st  = E_WAIT;
                     end
                  end
                  PH_DATA: begin
                     if (r.mode inside {MODE_WRRD, MODE_RDDATA}) begin
                        next_r.rxdata  = order_word(r.rx_sh, r.word32, r.big); // RL3
                        next_r.rx_full = 1'b1;
                        rx_store       = 1'b1;
                     end
                     next_r.left = r.left - LEN_W'(1);
                     if (r.left != LEN_W'(1)) begin
                        next_r.run = 1'b0;
                        next_r.st  = E_WAIT;
                     end else if (r.stat_en) begin
                        // Status word follows at once, clock kept running
                        next_r.ph    = PH_STAT;                             // RL14 RL26
                        next_r.tx_sh = '0;
                        next_r.mosi  = 1'b0;
                     end else begin
                        fin = 1'b1;
                     end
                  end
                  PH_STAT: begin
                     next_r.devstat = order_word(r.rx_sh, r.word32, r.big); // RL14
                     fin            = 1'b1;
                  end
                  default: begin
                     fin = 1'b1;
                  end
               endcase
            end
         end
         E_WAIT: begin
            // Clock parked low until software has room or data
            if (r.mode inside {MODE_WRRD, MODE_RDDATA}) begin
               if (!r.rx_full) begin
                  next_r.tx_sh = '0;
                  next_r.mosi  = 1'b0;
                  next_r.run   = 1'b1;
                  next_r.st    = E_SHIFT;
               end
            end else if (r.wake || r.tx_full) begin
               next_r.tx_sh   = order_word(r.wake ? WAKE_WORD : r.txdata, r.word32, r.big); // RL23
               next_r.mosi    = next_r.tx_sh[31];
               next_r.tx_full = r.wake && r.tx_full;
               next_r.run     = 1'b1;
               next_r.st      = E_SHIFT;
            end
         end
         E_END: begin
            next_r.cs_n = 1'b1;                                             // RL27 RL13
            next_r.done = 1'b1;
            next_r.wake = 1'b0;
            next_r.st   = E_IDLE;
         end
      endcase

      if (fin) begin
         next_r.run = 1'b0;
         next_r.st  = E_END;
         if (r.mode inside {MODE_WRITE, MODE_CMD}) begin
            next_r.prep = 1'b1;                                             // RL12
         end
      end

      // A write after the engine took the old word must not be lost
      if (wr && paddr_i == OFS_TXDATA) begin
         next_r.txdata  = pwdata_i;
         next_r.tx_full = 1'b1;
      end

      // Read data is latched in the setup cycle
      if (setup) begin
         unique case (paddr_i)
            OFS_CTRL: begin
               rd[CTRL_MODE +: 2] = r.mode;
               rd[CTRL_WORD32]    = r.word32;
               rd[CTRL_BIG]       = r.big;
               rd[CTRL_STAT_EN]   = r.stat_en;
               rd[CTRL_IRQ_POL]   = r.irq_pol;
            end
            OFS_CMD:     rd = r.cmd;
            OFS_LEN:     rd[LEN_W-1:0] = r.len;
            OFS_TXDATA:  rd = r.txdata;
            OFS_RXDATA:  rd = r.rxdata;
            OFS_STATUS: begin
               rd[STS_BUSY]    = (r.st != E_IDLE);
               rd[STS_TX_FULL] = r.tx_full;
               rd[STS_RX_FULL] = r.rx_full;
               rd[STS_DONE]    = r.done;
               rd[STS_REFUSED] = r.refused;
               rd[STS_IRQ]     = irq_act;                                   // RL22
               rd[STS_DEV_ERR] = |r.devstat[DST_OVERFLOW:DST_NOT_AVAIL];   // RL16
               rd[STS_PREP]    = r.prep;
               rd[STS_PKT_IRQ] = r.devstat[DST_PKT_IRQ];                   // RL17
               rd[STS_PKT_AVL] = r.devstat[DST_PKT_AVAIL];                 // RL18
            end
            OFS_DEVSTAT: rd = r.devstat;
            default:     rd = '0;
         endcase
         next_r.prdata = rd;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r         <= '0;
         r.word32  <= RST_WORD32;
         r.big     <= RST_BIG;
         r.stat_en <= RST_STAT_EN;
         r.irq_pol <= RST_IRQ_POL;
         r.cs_n    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata_o         = r.prdata;
   assign sclk_o           = lk.sclk;
   assign cs_n_o           = r.cs_n;
   assign serial_data_in_o = r.mosi;

   // Checks
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_cs_idle;
      r.st == E_IDLE |-> cs_n_o;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("chip select low while idle"); // RL27

   property p_sclk_parked;
      cs_n_o |-> !sclk_o;
   endproperty
   a_sclk_parked: assert property (p_sclk_parked) else $error("serial clock high outside frame"); // RL9

   property p_mosi_low_clk;
      $changed(serial_data_in_o) && !cs_n_o |-> !sclk_o;
   endproperty
   a_mosi_low_clk: assert property (p_mosi_low_clk) else $error("data changed while clock high"); // RL9

   property p_sclk_hold;
      $changed(sclk_o) |=> $stable(sclk_o);
   endproperty
   a_sclk_hold: assert property (p_sclk_hold) else $error("serial clock phase too short"); // RL5

   property p_frame_len;
      r.left <= WORDS_MAX;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("transfer longer than frame limit"); // RL6

   property p_word_wrap;
      $rose(r.word_done) |-> r.cnt == '0 ##1 !lk.rise [*1];
   endproperty
   a_word_wrap: assert property (p_word_wrap) else $error("word boundary not on bit count wrap"); // RL2

   property p_cs_fall_cnt;
      $fell(cs_n_o) |-> r.cnt == '0 && !r.word_done;
   endproperty
   a_cs_fall_cnt: assert property (p_cs_fall_cnt) else $error("bit count not cleared at frame start"); // RL4

   property p_rd_refused;
      refuse_rd && r.st == E_IDLE |=> r.refused && r.st == E_IDLE && cs_n_o;
   endproperty
   a_rd_refused: assert property (p_rd_refused) else $error("unprepared read was started"); // RL12

   property p_split_end;
      r.st == E_END |=> cs_n_o && r.st == E_IDLE && r.done;
   endproperty
   a_split_end: assert property (p_split_end) else $error("chip select not raised at end"); // RL13

   property p_rx_order;
      rx_store |=> r.rxdata == order_word($past(r.rx_sh), r.word32, r.big) && r.rx_full;
   endproperty
   a_rx_order: assert property (p_rx_order) else $error("read word stored in wrong byte order"); // RL3

   property p_stat_phase;
      r.st == E_SHIFT && r.ph == PH_STAT |-> r.stat_en;
   endproperty
   a_stat_phase: assert property (p_stat_phase) else $error("status word read while disabled"); // RL14
endmodule : generic_serial_host_mode_host

// File: generic_serial_host_mode_dev_model.sv
`timescale 1ns/10ps
module generic_serial_host_mode_dev_model
   import generic_serial_host_mode_host_pkg::*;
#(
   parameter logic [31:0] RESP0 = 32'h5a3c_0f96,
   parameter logic [31:0] RESP1 = 32'h0000_8109
) (
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   output logic             irq_o,
   output logic [31:0]      cmd_o,
   output logic [31:0]      dat_o
);
   int unsigned n;
   int unsigned k;
   bit          rd_pend;
   logic [31:0] sh;
   logic [31:0] w;
   initial begin
      n = 0;
      sh = '0;
      sdo_o = 1'b0;
      irq_o = 1'b0;
      cmd_o = '0;
      dat_o = '0;
   end
   // New frame restarts the count; line quiet while the command arrives
   always @(negedge cs_n_i) begin
      n = 0;
      // Split read data shows its first bit before the first edge
      sdo_o = rd_pend ? RESP0[31] : 1'b0;
   end
   // No pull on the line, so a released line shows the inverse of its last bit
   always @(posedge cs_n_i) begin
      sdo_o = ~sdo_o;
      // A command-only frame leaves the data half of a split read pending
      rd_pend = (n == 32) && !rd_pend;
      if (n >= 64 && dat_o == WAKE_WORD) irq_o = 1'b1;
   end
   // Rising edge only: capture, then launch the reply stream from the last command edge
   always @(posedge sclk_i) begin
      if (!cs_n_i) begin
         sh = {sh[30:0], sdi_i};
         n = n + 1;
         if (n == 32) cmd_o = sh;
         if (n == 64) dat_o = sh;
         // No command slot in a split read data frame
         k = rd_pend ? n + 32 : n;
         w = (((k - 32) / 32) % 2) ? RESP1 : RESP0;
         if (k >= 32) sdo_o <= #1 w[31 - (k - 32) % 32];
      end
   end
endmodule : generic_serial_host_mode_dev_model

// File: tb_generic_serial_host_mode_host.sv
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_generic_serial_host_mode_host;
   import generic_serial_host_mode_host_pkg::*;
   logic        clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, err;
   logic        sclk, cs_n, sdi, sdo, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, st, cmd, dat;
   int          mismatches, total_checks;
   logic [31:0] ctl [4] = '{32'h69, 32'h41, 32'h79, 32'h51};
   logic [31:0] ec [4] = '{32'ha1b2_c3d4, 32'hc3d4_a1b2, 32'hd4c3_b2a1, 32'hd4c3_b2a1};
   logic [31:0] ed [4] = '{32'h1122_3344, 32'h3344_1122, 32'h4433_2211, 32'h4433_2211};
   generic_serial_host_mode_host #(.SCLK_HALF(4)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sclk_o(sclk), .cs_n_o(cs_n), .serial_data_in_o(sdi),
      .serial_data_out_i(sdo), .dev_irq_i(irq));
   generic_serial_host_mode_dev_model dev (.sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .irq_o(irq),
      .cmd_o(cmd), .dat_o(dat));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // One APB transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   // One-word transaction, then wait for done and clear it
   task run(input logic [31:0] c, input logic [31:0] k);
      apb(1'b1, OFS_LEN, 32'h1);
      apb(1'b1, OFS_CMD, c);
      apb(1'b1, OFS_CTRL, k);
      rd = '0;
      while (rd[STS_DONE] !== 1'b1) apb(1'b0, OFS_STATUS, '0);
      st = rd;
      apb(1'b1, OFS_STATUS, 32'h18);
   endtask : run
   // Hang guard, well beyond the few thousand cycles the tests need
   initial begin
      repeat (50000) @(posedge clk_i);
      mismatches++;
      print_verdict;
   end
   initial begin
      arst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      apb(1'b0, OFS_CTRL, '0); `CHK(rd, 32'h60)
      apb(1'b0, 8'h1c, '0); `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, OFS_LEN, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h6f); apb(1'b0, OFS_STATUS, '0); `CHK({cs_n, rd}, {1'b1, 32'h10})
      apb(1'b1, OFS_STATUS, 32'h10);
      $display("test reset_refuse done");
      run(32'h4c00_0104, 32'h6b); `CHK(st, 32'h34c)
      `CHK(cmd, 32'h4c00_0104)
      apb(1'b0, OFS_RXDATA, '0); `CHK(rd, 32'h5a3c_0f96)
      apb(1'b0, OFS_DEVSTAT, '0); `CHK(rd, 32'h0000_8109)
      $display("test write_read done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_TXDATA, 32'h1122_3344);
         run(32'ha1b2_c3d4, ctl[i]);
         `CHK(cmd, ec[i])
         `CHK({st[STS_PREP], dat}, {1'b1, ed[i]})
      end
      $display("test order_table done");
      run(32'h0c00_0204, 32'h6d); `CHK({st[STS_PREP], cmd}, {1'b1, 32'h0c00_0204})
      run(32'h0, 32'h6f); `CHK(st, 32'h34c)
      apb(1'b0, OFS_RXDATA, '0); `CHK(rd, 32'h5a3c_0f96)
      $display("test split_read done");
      run(32'h8000_0000, 32'he9); `CHK(dat, WAKE_WORD)
      apb(1'b0, OFS_STATUS, '0); `CHK(rd[STS_IRQ], 1'b1)
      apb(1'b1, OFS_CTRL, 32'h28); apb(1'b0, OFS_STATUS, '0); `CHK(rd[STS_IRQ], 1'b0)
      $display("test wake_irq done");
      print_verdict;
   end
endmodule : tb_generic_serial_host_mode_host
